// ---- include/rst_gen_pkg.sv ----
package rst_gen_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 25000000;
    // pin pulse lengths in fc periods; the block clock stands in for fc
    localparam int PULSE_MIN_FC = 8;
    localparam int PULSE_MAX_FC = 24;
    localparam int PULSE_FC = 16;
    localparam int EXT_MIN_FC = 12;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(PULSE_FC);
    localparam logic [CNT_W-1:0] EXT_CYC = CNT_W'(EXT_MIN_FC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // ----------------------------------------
    // memory map
    // ----------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [ADDR_W-1:0] VEC_LO = 20'hFFFFC;
    localparam logic [ADDR_W-1:0] VEC_MID = 20'hFFFFD;
    localparam logic [ADDR_W-1:0] VEC_HI = 20'hFFFFE;
    localparam logic [ADDR_W-1:0] SFR_LO = 20'h00000;
    localparam logic [ADDR_W-1:0] SFR_HI = 20'h0003F;
    localparam logic [ADDR_W-1:0] RAM_LO = 20'h00040;
    localparam logic [ADDR_W-1:0] RAM_HI = 20'h0083F;

    // ----------------------------------------
    // register map (wishbone, byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_SYSCTL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CORE = 8'h08;
    localparam int MAIN_OSC_BIT = 7;
    localparam int LOWF_OSC_BIT = 6;
    localparam int SYSCLK_SEL_BIT = 5;
    localparam logic [7:0] SYSCTL_RST = 8'hC0;

    // cause codes in the status register
    localparam int CAUSE_EXT = 0;
    localparam int CAUSE_TRAP = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_CLK = 3;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_PULSE = 2'b01,
        ST_EXT = 2'b10,
        ST_VEC = 2'b11
    } phase_e;

    typedef struct packed {
        logic master_irq_enable;
        logic [15:0] individual_irq_enables;
        logic [15:0] irq_latches;
        logic [3:0] bank_selector;
        logic jump_status_flag;
        logic wdt_enable;
        logic [7:0] prescaler;
    } core_init_s;

endpackage

// ---- src/pulse_stretch.sv ----
`timescale 1ns/10ps

// holds a request high for a fixed count once triggered
module pulse_stretch
    import rst_gen_pkg::*;
#(
    parameter logic [CNT_W-1:0] LEN = PULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // trigger and stretched output
    input wire logic trig_i,
    output logic busy_o
);

    logic [CNT_W-1:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= CNT_ZERO;
        end else if (trig_i && cnt == CNT_ZERO) begin
            cnt <= LEN;
        end else if (cnt != CNT_ZERO) begin
            cnt <= cnt - 5'h01;
        end
    end

    assign busy_o = (cnt != CNT_ZERO);

endmodule

// ---- src/mcu_reset_generator.sv ----
`timescale 1ns/10ps

// What this block does
// [RL1] merge external pin, address trap, watchdog and clock stop into one reset
// [RL2] fault detectors are not cleared by power-up itself
// [RL3] at power-up the pin is driven low at most 24 fc periods; this block keeps the pin released at power-up
// [RL4] outside party holds the pin low at least 12 fc for full reset
// [RL5] stay in reset while pin low, leave when it returns high
// [RL6] on release load pc from vector bytes at top of memory
// [RL7] fetch from ram or sfr area raises address-trap reset
// [RL8] address-trap reset drives pin low for 8 to 24 fc
// [RL9] both oscillator enables cleared together gives a clock reset
// [RL10] clock reset drives pin from released to low for 8 to 24 fc
// [RL11] reset clears master irq enable, individual enables and latches
// [RL12] reset sets bank selector 0, jump flag 1, leaves others alone
// [RL13] reset clears prescaler and divider, leaves watchdog enabled
// [RL14] stopping the selected system clock counts as deadlock
// [RL15] pin is open drain, released when no internal reset
module mcu_reset_generator
    import rst_gen_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // reset pin (open drain)
    input wire logic reset_pin_n_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    // cpu side
    input wire logic fetch_i,
    input wire logic [ADDR_W-1:0] fetch_addr_i,
    input wire logic wdt_req_i,
    input wire logic [7:0] vec_data_i,
    output logic [ADDR_W-1:0] vec_addr_o,
    output logic core_rst_o,
    output logic pc_load_o,
    output logic [ADDR_W-1:0] pc_o,
    output core_init_s core_init_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    phase_e phase;
    logic [7:0] sysctl;
    logic [3:0] cause;
    logic [CNT_W-1:0] ext_cnt;
    logic [1:0] vec_idx;
    logic [ADDR_W-1:0] pc_acc;
    logic stretch_busy;
    logic stretch_clr;
    logic trap_hit;
    logic clk_stop;
    logic internal_req;
    logic wr_sysctl;
    logic [7:0] next_sysctl;

    // ----------------------------------------
    // fault detection
    // ----------------------------------------
    always_comb begin
        trap_hit = fetch_i && !core_rst_o &&
            ((fetch_addr_i >= SFR_LO && fetch_addr_i <= SFR_HI) ||
             (fetch_addr_i >= RAM_LO && fetch_addr_i <= RAM_HI)); // see [RL7]
    end

    assign wr_sysctl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
        wb_adr_i == REG_SYSCTL && wb_sel_i[0];
    assign next_sysctl = wr_sysctl ? wb_dat_i[7:0] : sysctl;

    // catch the bad write itself so the oscillator never really stops
    always_comb begin
        clk_stop = !next_sysctl[MAIN_OSC_BIT] &&
            !next_sysctl[LOWF_OSC_BIT]; // see [RL9]
        if (!next_sysctl[SYSCLK_SEL_BIT] && !next_sysctl[MAIN_OSC_BIT]) begin
            clk_stop = 1'b1; // see [RL14]
        end
        if (next_sysctl[SYSCLK_SEL_BIT] && !next_sysctl[LOWF_OSC_BIT]) begin
            clk_stop = 1'b1; // see [RL14]
        end
    end

    assign internal_req = trap_hit || wdt_req_i || clk_stop; // see [RL1]

    // cleared while the vector is fetched, never by power-up itself; until
    // then its count may be unknown, and only the pulse phase reads it
    assign stretch_clr = (phase == ST_VEC);

    pulse_stretch #(
        .LEN(PULSE_CYC)
    ) u_stretch (
        .clk_i(clk_i),
        .rst_i(stretch_clr), // see [RL2]
        .trig_i(internal_req),
        .busy_o(stretch_busy)
    );

    // ----------------------------------------
    // system control register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysctl <= SYSCTL_RST;
        end else if (wr_sysctl && !clk_stop) begin
            sysctl <= wb_dat_i[7:0];
        end else if (phase == ST_PULSE) begin
            sysctl <= SYSCTL_RST; // see [RL9]
        end
    end

    // ----------------------------------------
    // reset sequencing
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= ST_EXT;
            ext_cnt <= CNT_ZERO;
        end else begin
            case (phase)
                ST_RUN: begin
                    if (internal_req) begin
                        phase <= ST_PULSE; // see [RL1]
                    end else if (!reset_pin_n_i) begin
                        phase <= ST_EXT; // see [RL5]
                    end
                end
                ST_PULSE: begin
                    if (!stretch_busy && !internal_req) begin
                        phase <= ST_EXT;
                    end
                end
                ST_EXT: begin
                    if (reset_pin_n_i) begin
                        phase <= ST_VEC; // see [RL5]
                    end
                end
                ST_VEC: begin
                    if (!reset_pin_n_i) begin
                        phase <= ST_EXT;
                    end else if (vec_idx == 2'd2) begin
                        phase <= ST_RUN; // see [RL6]
                    end
                end
                default: phase <= ST_EXT;
            endcase
            if (!reset_pin_n_i && ext_cnt != EXT_CYC) begin
                ext_cnt <= ext_cnt + 5'h01; // pin-low length, read by checks
            end else if (reset_pin_n_i) begin
                ext_cnt <= CNT_ZERO;
            end
        end
    end

    // ----------------------------------------
    // vector fetch
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_idx <= 2'd0;
            pc_acc <= 20'h00000;
        end else if (phase == ST_VEC) begin
            vec_idx <= vec_idx + 2'd1;
            case (vec_idx)
                2'd0: pc_acc[7:0] <= vec_data_i; // see [RL6]
                2'd1: pc_acc[15:8] <= vec_data_i;
                default: pc_acc[19:16] <= vec_data_i[3:0];
            endcase
        end else begin
            vec_idx <= 2'd0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_addr_o <= VEC_LO;
        end else if (phase == ST_VEC && vec_idx == 2'd0) begin
            vec_addr_o <= VEC_MID;
        end else if (phase == ST_VEC && vec_idx == 2'd1) begin
            vec_addr_o <= VEC_HI;
        end else begin
            vec_addr_o <= VEC_LO;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_load_o <= 1'b0;
            pc_o <= 20'h00000;
        end else begin
            pc_load_o <= (phase == ST_VEC && vec_idx == 2'd2);
            if (phase == ST_VEC && vec_idx == 2'd2) begin
                pc_o <= {vec_data_i[3:0], pc_acc[15:0]}; // see [RL6]
            end
        end
    end

    // ----------------------------------------
    // outputs: pin and core reset
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_pin_o <= 1'b0;
            reset_pin_oe_o <= 1'b0; // see [RL3]
            core_rst_o <= 1'b1;
        end else begin
            reset_pin_o <= 1'b0; // see [RL15]
            reset_pin_oe_o <= (phase == ST_PULSE) ||
                (phase == ST_RUN && internal_req); // see [RL8] [RL10]
            core_rst_o <= (phase != ST_RUN) || internal_req ||
                !reset_pin_n_i; // see [RL5]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_init_o.master_irq_enable <= 1'b0;
            core_init_o.individual_irq_enables <= 16'h0000;
            core_init_o.irq_latches <= 16'h0000;
            core_init_o.bank_selector <= 4'h0;
            core_init_o.jump_status_flag <= 1'b1;
            core_init_o.wdt_enable <= 1'b1;
            core_init_o.prescaler <= 8'h00;
        end else begin
            core_init_o.master_irq_enable <= 1'b0; // see [RL11]
            core_init_o.individual_irq_enables <= 16'h0000; // see [RL11]
            core_init_o.irq_latches <= 16'h0000; // see [RL11]
            core_init_o.bank_selector <= 4'h0; // see [RL12]
            core_init_o.jump_status_flag <= 1'b1; // see [RL12]
            core_init_o.wdt_enable <= 1'b1; // see [RL13]
            core_init_o.prescaler <= 8'h00; // see [RL13]
        end
    end

    // ----------------------------------------
    // cause record and wishbone slave
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause <= 4'h0;
        end else if (phase == ST_RUN) begin
            if (internal_req || !reset_pin_n_i) begin
                cause <= {clk_stop, wdt_req_i, trap_hit,
                    !internal_req && !reset_pin_n_i};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            case (wb_adr_i)
                REG_SYSCTL: wb_dat_o <= {24'h000000, sysctl};
                REG_STATUS: wb_dat_o <= {26'h0, phase, cause};
                REG_CORE: wb_dat_o <= {12'h000, pc_o};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence pulse_seq;
        reset_pin_oe_o [*8];
    endsequence

    property pin_pulse_p;
        @(posedge clk_i) disable iff (rst_i)
        $rose(reset_pin_oe_o) |-> pulse_seq;
    endproperty
    pin_pulse_min_a: assert property (pin_pulse_p) // see [RL8]
        else $error("reset pin pulse shorter than 8 cycles");

    pin_pulse_max_a: assert property ( // see [RL10]
        @(posedge clk_i) disable iff (rst_i)
        $rose(reset_pin_oe_o) |-> ##[1:24] !reset_pin_oe_o)
        else $error("reset pin pulse longer than 24 cycles");

    trap_detect_a: assert property ( // see [RL7]
        @(posedge clk_i) disable iff (rst_i)
        trap_hit |=> core_rst_o && reset_pin_oe_o)
        else $error("trap fetch did not reset");

    clk_stop_a: assert property ( // see [RL9]
        @(posedge clk_i) disable iff (rst_i)
        clk_stop |=> core_rst_o)
        else $error("clock stop did not reset");

    pin_hold_a: assert property ( // see [RL5]
        @(posedge clk_i) disable iff (rst_i)
        !reset_pin_n_i |=> core_rst_o)
        else $error("core left reset while pin low");

    pin_drive_a: assert property ( // see [RL15]
        @(posedge clk_i) disable iff (rst_i)
        reset_pin_oe_o |-> !reset_pin_o)
        else $error("reset pin driven high");

    vec_load_a: assert property ( // see [RL6]
        @(posedge clk_i) disable iff (rst_i)
        pc_load_o |-> $past(vec_addr_o) == VEC_HI && core_rst_o)
        else $error("pc load out of sequence");

    init_vals_a: assert property ( // see [RL11] [RL12]
        @(posedge clk_i) disable iff (rst_i)
        core_rst_o |-> core_init_o.jump_status_flag &&
        core_init_o.bank_selector == 4'h0 &&
        !core_init_o.master_irq_enable)
        else $error("core init values wrong");

    wdt_merge_a: assert property ( // see [RL1]
        @(posedge clk_i) disable iff (rst_i)
        wdt_req_i |=> core_rst_o)
        else $error("watchdog request did not reset");

    sequence pin_released_s;
        !reset_pin_oe_o;
    endsequence

    sequence pin_driven_s;
        reset_pin_oe_o && !reset_pin_o;
    endsequence

    property pin_release_drive_p;
        @(posedge clk_i) disable iff (rst_i)
        (phase == ST_RUN && internal_req) |-> pin_released_s ##1 pin_driven_s;
    endproperty
    pin_release_drive_a: assert property (pin_release_drive_p) // see [RL10]
        else $error("reset pin not driven from released state");

    clk_restore_a: assert property ( // see [RL9]
        @(posedge clk_i) disable iff (rst_i)
        phase == ST_PULSE && !wr_sysctl |=> sysctl == SYSCTL_RST)
        else $error("oscillator enables not restored");

    ext_full_a: assert property ( // see [RL5]
        @(posedge clk_i) disable iff (rst_i)
        ext_cnt == EXT_CYC |-> core_rst_o)
        else $error("long pin low did not hold reset");

    vec_order_a: assert property ( // see [RL6]
        @(posedge clk_i) disable iff (rst_i)
        phase == ST_VEC && vec_idx == 2'd0 |=> vec_addr_o == VEC_MID)
        else $error("vector bytes read out of order");

endmodule

// ---- verification/ext_reset_model.sv ----
`timescale 1ns/10ps

// ----------------------------------------
// board reset line: pull-up, outside switch, device open drain
// ----------------------------------------
module ext_reset_model (
    // clock
    input wire logic clk_i,
    // request from the bench
    input wire logic start_i,
    input wire logic [7:0] len_i,
    // device pin driver
    input wire logic pin_i,
    input wire logic pin_oe_i,
    // resolved line
    output logic pin_n_o
);
    logic [7:0] cnt = 8'h00;

    always_ff @(posedge clk_i) begin
        if (start_i) begin
            cnt <= len_i;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end

    // a released line rises through the pull-up, never keeps a stale low
    assign pin_n_o = !((cnt != 8'h00) || (pin_oe_i && !pin_i));
endmodule

// ---- verification/mcu_reset_generator_test.sv ----
`timescale 1ns/10ps

module mcu_reset_generator_test;
    import rst_gen_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fetch_i = 1'b0;
    logic [ADDR_W-1:0] fetch_addr_i = 20'h00000;
    logic wdt_req_i = 1'b0;
    logic [7:0] vec_data_i;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic ext_start = 1'b0;
    logic [7:0] ext_len = 8'h00;
    logic pin_n, pin_o, pin_oe, core_rst_o, pc_load_o, wb_ack_o;
    logic [ADDR_W-1:0] vec_addr_o, pc_o;
    logic [31:0] wb_dat_o, rd;
    core_init_s core_init_o, init_exp;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // vector bytes give a program counter of A1234
    always_comb begin
        case (vec_addr_o)
            VEC_LO: vec_data_i = 8'h34;
            VEC_MID: vec_data_i = 8'h12;
            VEC_HI: vec_data_i = 8'hFA;
            default: vec_data_i = 8'hFF;
        endcase
    end

    ext_reset_model i_board (.clk_i(clk_i), .start_i(ext_start),
        .len_i(ext_len), .pin_i(pin_o), .pin_oe_i(pin_oe), .pin_n_o(pin_n));

    mcu_reset_generator i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .reset_pin_n_i(pin_n), .reset_pin_o(pin_o), .reset_pin_oe_o(pin_oe),
        .fetch_i(fetch_i), .fetch_addr_i(fetch_addr_i), .wdt_req_i(wdt_req_i),
        .vec_data_i(vec_data_i), .vec_addr_o(vec_addr_o),
        .core_rst_o(core_rst_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
        .core_init_o(core_init_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    // ----------------------------------------
    // checks and bus access
    // ----------------------------------------
    task automatic check_val(string name, logic [63:0] exp, logic [63:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask

    task automatic check_len(string name, int got);
        compares++;
        if (got < PULSE_MIN_FC || got > PULSE_MAX_FC) begin
            errors++;
            $display("unexpected %s: expected 8 to 24, seen %0d", name, got);
        end
    endtask

    task automatic wb_cycle(logic we, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n == 20) errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic expect_boot();
        int n;
        n = 0;
        while (pc_load_o !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_val("pc", 20'hA1234, pc_o);
        check_val("core init", init_exp, core_init_o);
        repeat (2) @(posedge clk_i);
        #1;
        check_val("core reset", 1'b0, core_rst_o);
    endtask

    // trap address or watchdog request for one cycle
    task automatic fault(logic [ADDR_W-1:0] a, logic w);
        @(posedge clk_i);
        fetch_i <= !w;
        fetch_addr_i <= a;
        wdt_req_i <= w;
        @(posedge clk_i);
        fetch_i <= 1'b0;
        wdt_req_i <= 1'b0;
        #1;
    endtask

    task automatic expect_reset(int cause);
        int n;
        n = 0;
        while (core_rst_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_val("core reset", 1'b1, core_rst_o);
        n = 0;
        while (pin_oe === 1'b1 && pin_o === 1'b0 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_len("pin pulse", n);
        expect_boot();
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check_val("cause", 1'b1, rd[cause]);
    endtask

    task automatic finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        init_exp = '0;
        init_exp.jump_status_flag = 1'b1;
        init_exp.wdt_enable = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check_val("pin enable", 1'b0, pin_oe);
        expect_boot();
        wb_cycle(1'b0, REG_SYSCTL, 32'h0);
        check_val("sysctl", 8'hC0, rd[7:0]);
        wb_cycle(1'b0, REG_CORE, 32'h0);
        check_val("pc reg", 20'hA1234, rd[ADDR_W-1:0]);
        wb_cycle(1'b0, 8'h0C, 32'h0);
        check_val("unmapped", 32'h0, rd);
        @(posedge clk_i);
        ext_start <= 1'b1;
        ext_len <= 8'h0C;
        @(posedge clk_i);
        ext_start <= 1'b0;
        repeat (9) @(posedge clk_i);
        #1;
        check_val("held reset", 1'b1, core_rst_o);
        check_val("pin enable", 1'b0, pin_oe);
        expect_boot();
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check_val("cause", 1'b1, rd[CAUSE_EXT]);
        fault(RAM_LO, 1'b0);
        expect_reset(CAUSE_TRAP);
        fault(RAM_HI, 1'b0);
        expect_reset(CAUSE_TRAP);
        fault(SFR_LO, 1'b0);
        expect_reset(CAUSE_TRAP);
        fault(SFR_HI, 1'b0);
        expect_reset(CAUSE_TRAP);
        fault(20'h00840, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        check_val("no trap", 1'b0, core_rst_o);
        fault(20'h00840, 1'b1);
        expect_reset(CAUSE_WDT);
        wb_cycle(1'b1, REG_SYSCTL, 32'h00);
        expect_reset(CAUSE_CLK);
        wb_cycle(1'b0, REG_SYSCTL, 32'h0);
        check_val("sysctl", 8'hC0, rd[7:0]);
        wb_cycle(1'b1, REG_SYSCTL, 32'h40);
        expect_reset(CAUSE_CLK);
        wb_cycle(1'b1, REG_SYSCTL, 32'h80);
        repeat (3) @(posedge clk_i);
        #1;
        check_val("no clock reset", 1'b0, core_rst_o);
        wb_cycle(1'b0, REG_SYSCTL, 32'h0);
        check_val("sysctl", 8'h80, rd[7:0]);
        // low-frequency clock selected while its enable is already cleared
        wb_cycle(1'b1, REG_SYSCTL, 32'hA0);
        expect_reset(CAUSE_CLK);
        wb_cycle(1'b0, REG_SYSCTL, 32'h0);
        check_val("sysctl", 8'hC0, rd[7:0]);
        finish_test();
    end
endmodule
